// ===== bsns_consts.vh
/*
 constants for the borrow-subtract / nibble-exchange datapath.
 assumes the including file is plain verilog-2005 on one clock.
*/
// Operation
// RL1 - subtract-with-borrow gives operand minus working register minus the inverted carry, in two's complement.
// RL2 - destination-select 0 writes the result to the working register and leaves the operand register alone.
// RL3 - destination-select 1 writes the result back into the operand register.
// RL4 - access-select 0 addresses the operand in the fixed shared bank, ignoring the bank select register.
// RL5 - access-select 1 forms the operand address from the bank select register.
// RL6 - nibble exchange swaps the upper and lower four bits of the operand.
// RL7 - each instruction takes one cycle of four phases: decode, read, compute, write.
`ifndef BSNS_CONSTS_VH
`define BSNS_CONSTS_VH
`define BSNS_PH_DECODE  2'h0
`define BSNS_PH_READ    2'h1
`define BSNS_PH_COMPUTE 2'h2
`define BSNS_PH_WRITE   2'h3
`define BSNS_OP_SUBB    1'h0
`define BSNS_OP_SWAP    1'h1
`define BSNS_SHARED_BANK 4'h0
`define BSNS_WORKING_REGISTER_RST   8'h00
`define BSNS_NIB_HI     7:4
`define BSNS_NIB_LO     3:0
`define BSNS_NIB_W      4
`define BSNS_DATA_BITS  7:0
`define BSNS_CARRY_BIT  8
`define BSNS_PAD_BYTE   8'h00
`define BSNS_DATA_RST   8'h00
`define BSNS_ADDR_RST   12'h000
`endif

// ===== bsns_datapath.v
/*
 datapath executing subtract-with-borrow and nibble exchange on one data-memory operand.
 assumes a data memory with combinational read (mem_rdata follows mem_addr) and
 registered write on mem_we; start comes from logic on the same clock.
*/
`include "bsns_consts.vh"
module bsns_datapath (
  clock,
  rstn,
  start,
  op_sel,
  file_addr,
  dest_sel,
  access_sel,
  bank_select_register,
  carry_in,
  mem_rdata,
  mem_addr,
  mem_wdata,
  mem_we,
  working_register,
  borrow_out,
  busy,
  done
);
  input  wire        clock;
  input  wire        rstn;
  input  wire        start;
  input  wire        op_sel;
  input  wire [7:0]  file_addr;
  input  wire        dest_sel;
  input  wire        access_sel;
  input  wire [3:0]  bank_select_register;
  input  wire        carry_in;
  input  wire [7:0]  mem_rdata;
  output reg  [11:0] mem_addr;
  output reg  [7:0]  mem_wdata;
  output reg         mem_we;
  output reg  [7:0]  working_register;
  output reg         borrow_out;
  output reg         busy;
  output reg         done;

  // phase codes of the four-quarter instruction cycle
  localparam [1:0] PH_DECODE  = `BSNS_PH_DECODE;
  localparam [1:0] PH_READ    = `BSNS_PH_READ;
  localparam [1:0] PH_COMPUTE = `BSNS_PH_COMPUTE;
  localparam [1:0] PH_WRITE   = `BSNS_PH_WRITE;

  // sequencer phase, the fields captured when an instruction is taken, and the operand, result and carry registers
  reg  [1:0]  phase;
  reg  [1:0]  next_phase;
  reg         op;
  reg         dest;
  reg         cin;
  reg  [7:0]  operand;
  reg  [7:0]  result;
  reg         carry;

  // phase-flag and operand-address helpers
  reg         take;
  reg         in_write;
  reg  [11:0] next_addr;

  // arithmetic helpers
  reg  [8:0]  sum_f;
  reg  [8:0]  sum_w;
  reg  [8:0]  sum_c;
  reg  [8:0]  diff;
  wire [7:0]  swapped;
  reg  [7:0]  next_result;
  reg         next_carry;

  // index for the per-bit nibble exchange
  genvar g;

  // phase flags: an instruction is taken only in the decode quarter,
  // so a start that arrives while busy is simply not seen
  always @* begin
    take     = (phase == PH_DECODE) && start; // [RL7]
    in_write = (phase == PH_WRITE);
  end

  // operand address: the shared bank, or the bank select register
  always @* begin
    if (access_sel) begin
      next_addr = {bank_select_register, file_addr}; // [RL5]
    end else begin
      next_addr = {`BSNS_SHARED_BANK, file_addr}; // [RL4]
    end
  end

  // quarter order: decode, read, compute, write, then decode again
  always @* begin
    case (phase)
      PH_DECODE: begin
        if (take) begin
          next_phase = PH_READ; // [RL7]
        end else begin
          next_phase = PH_DECODE;
        end
      end
      PH_READ: begin
        next_phase = PH_COMPUTE; // [RL7]
      end
      PH_COMPUTE: begin
        next_phase = PH_WRITE; // [RL7]
      end
      PH_WRITE: begin
        next_phase = PH_DECODE; // [RL7]
      end
      default: begin
        next_phase = PH_DECODE;
      end
    endcase
  end

  // subtract with borrow: f - w - ~c worked as f + ~w + c in nine bits;
  // the ninth bit is the new carry, set when no borrow was needed
  always @* begin
    sum_f = {1'b0, operand};
    sum_w = {1'b0, ~working_register};
    sum_c = {`BSNS_PAD_BYTE, cin};
    diff  = sum_f + sum_w + sum_c; // [RL1]
  end

  // nibble exchange, one bit of each half per pass
  generate
    for (g = 0; g < `BSNS_NIB_W; g = g + 1) begin : g_swap
      assign swapped[g + `BSNS_NIB_W] = operand[g];               // [RL6]
      assign swapped[g]               = operand[g + `BSNS_NIB_W]; // [RL6]
    end
  endgenerate

  // result and new carry of the captured operation; the exchange
  // does not touch the carry, so it passes through unchanged
  always @* begin
    if (op == `BSNS_OP_SWAP) begin
      next_result = swapped; // [RL6]
      next_carry  = cin;
    end else begin
      next_result = diff[`BSNS_DATA_BITS]; // [RL1]
      next_carry  = diff[`BSNS_CARRY_BIT];
    end
  end

  // phase register
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase <= PH_DECODE;
    end else begin
      phase <= next_phase; // [RL7]
    end
  end

  // busy from the taking edge until the write quarter ends
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
    end else if (take) begin
      busy <= 1'b1; // [RL7]
    end else if (in_write) begin
      busy <= 1'b0;
    end
  end

  // done pulses for one cycle as the write quarter ends
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      done <= 1'b0;
    end else begin
      done <= in_write; // [RL7]
    end
  end

  // instruction fields captured in the decode quarter; they are held
  // because the inputs may move on while the cycle runs
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      op   <= `BSNS_OP_SUBB;
      dest <= 1'b0;
      cin  <= 1'b0;
    end else if (take) begin
      op   <= op_sel;
      dest <= dest_sel;
      cin  <= carry_in;
    end
  end

  // operand address, held until the next instruction is taken
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_addr <= `BSNS_ADDR_RST;
    end else if (take) begin
      mem_addr <= next_addr; // [RL4] [RL5]
    end
  end

  // second quarter: read the operand through the combinational memory port
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      operand <= `BSNS_DATA_RST;
    end else if (phase == PH_READ) begin
      operand <= mem_rdata; // [RL7]
    end
  end

  // third quarter: process the data
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result <= `BSNS_DATA_RST;
      carry  <= 1'b0;
    end else if (phase == PH_COMPUTE) begin
      result <= next_result; // [RL1] [RL6]
      carry  <= next_carry;
    end
  end

  // fourth quarter, memory side: a one-cycle write strobe with the result
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_wdata <= `BSNS_DATA_RST;
      mem_we    <= 1'b0;
    end else begin
      mem_we <= in_write && dest; // [RL3]
      if (in_write && dest) begin
        mem_wdata <= result; // [RL3]
      end
    end
  end

  // fourth quarter, register side: the working register takes the result
  // only when the destination is not memory, so one write never hits both
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      working_register <= `BSNS_WORKING_REGISTER_RST;
    end else if (in_write && !dest) begin
      working_register <= result; // [RL2]
    end
  end

  // new carry, published with the result
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      borrow_out <= 1'b0;
    end else if (in_write) begin
      borrow_out <= carry; // [RL1]
    end
  end
endmodule

// ===== bsns_asserts.sv
/* port assertions for bsns_datapath.
   assumes one clock and rstn low-active async. */
module bsns_chk (
  input wire        clock,
  input wire        rstn,
  input wire        start,
  input wire        op_sel,
  input wire        dest_sel,
  input wire        access_sel,
  input wire        carry_in,
  input wire        mem_we,
  input wire        busy,
  input wire        done,
  input wire        borrow_out,
  input wire [7:0]  file_addr,
  input wire [7:0]  mem_rdata,
  input wire [7:0]  mem_wdata,
  input wire [7:0]  working_register,
  input wire [3:0]  bank_select_register,
  input wire [11:0] mem_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // an instruction is taken in idle
  wire       tk      = start && !busy;
  // operand with its halves exchanged, for the swap check
  wire [7:0] rd_swap = {mem_rdata[3:0], mem_rdata[7:4]};
  AST_PHASES: assert property (tk |=> busy [*3] ##1 (done && !busy)) else $error("bad phases");
  AST_SHARED: assert property (tk && !access_sel |=> mem_addr == {4'h0, $past(file_addr)}) else $error("bad addr");
  AST_BANKED: assert property (tk && access_sel |=>
    mem_addr == {$past(bank_select_register), $past(file_addr)}) else $error("bad bank");
  AST_TO_W: assert property (tk && !dest_sel |-> ##4 done && !mem_we) else $error("bad dest w");
  AST_TO_F: assert property (tk && dest_sel |-> ##4 mem_we && $stable(working_register)) else $error("bad dest f");
  AST_SUBB: assert property (tk && !op_sel && !dest_sel |-> ##4 working_register ==
    $past(mem_rdata, 3) - $past(working_register, 4) - !$past(carry_in, 4)) else $error("bad diff");
  AST_BORROW: assert property (tk && !op_sel |-> ##4 borrow_out ==
    ({1'b0, $past(mem_rdata, 3)} >= {1'b0, $past(working_register, 4)} + !$past(carry_in, 4)))
    else $error("bad borrow");
  AST_SWAP: assert property (tk && op_sel && dest_sel |-> ##4 mem_wdata == $past(rd_swap, 3))
    else $error("bad swap");
  AST_SWAP_C: assert property (tk && op_sel |-> ##4 borrow_out == $past(carry_in, 4)) else $error("bad swap c");
  C_SUB: cover property (tk && !op_sel);
  C_SWP: cover property (tk && op_sel);
  C_MEM: cover property (mem_we);
endmodule
bind bsns_datapath bsns_chk u_chk (
  .clock               (clock),
  .rstn                (rstn),
  .start               (start),
  .op_sel              (op_sel),
  .dest_sel            (dest_sel),
  .access_sel          (access_sel),
  .carry_in            (carry_in),
  .mem_we              (mem_we),
  .busy                (busy),
  .done                (done),
  .borrow_out          (borrow_out),
  .file_addr           (file_addr),
  .mem_rdata           (mem_rdata),
  .mem_wdata           (mem_wdata),
  .working_register    (working_register),
  .bank_select_register(bank_select_register),
  .mem_addr            (mem_addr)
);

// ===== borrow_subtract_nibble_swap_tb_top.sv
/* bench for bsns_datapath.
   assumes only the design and its checker. */
`define CHK(n,e,s) begin n_tests++; if ((s)!==(e)) begin fail_count++; $display("Error %s exp %h got %h",n,e,s); end end
module borrow_subtract_nibble_swap_tb_top;
  timeunit 1ns; timeprecision 1ns;
  reg         clock = 0, rstn = 0, start = 0, op_sel = 0, dest_sel = 0, access_sel = 0, carry_in = 0;
  reg  [7:0]  file_addr = 8'h00, mem[0:4095];
  reg  [3:0]  bank_select_register = 4'h0;
  wire [11:0] mem_addr;
  wire [7:0]  mem_wdata, working_register;
  wire        mem_we, busy, done, borrow_out;
  int         fail_count = 0, n_tests = 0;
  always #20 clock = ~clock;
  // data memory: combinational read, write on the strobe
  always @(posedge clock) if (mem_we) mem[mem_addr] <= mem_wdata;
  bsns_datapath u_dut (.clock(clock), .rstn(rstn), .start(start), .op_sel(op_sel), .file_addr(file_addr),
    .dest_sel(dest_sel), .access_sel(access_sel), .bank_select_register(bank_select_register), .carry_in(carry_in),
    .mem_rdata(mem[mem_addr]), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .working_register(working_register), .borrow_out(borrow_out), .busy(busy), .done(done));
  // one instruction, waiting for done under a bound
  task automatic run(input o, d, a, c, input [3:0] b, input [7:0] f);
    int i;
    @(posedge clock);
    {op_sel, dest_sel, access_sel, carry_in, bank_select_register, file_addr} <= {o, d, a, c, b, f};
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    for (i = 0; i < 9 && done !== 1'b1; i++) @(negedge clock);
    if (i == 9) begin
      fail_count++;
      summarize();
    end else begin
      @(posedge clock);
      #1;
    end
  endtask
  task summarize;
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    mem[12'h0ab] = 8'hd0; mem[12'h3ab] = 8'h77; mem[12'h319] = 8'h19;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    run(1, 0, 0, 1, 4'h3, 8'hab);
    `CHK("w", 8'h0d, working_register)
    `CHK("m0ab", 8'hd0, mem[12'h0ab])
    `CHK("c", 1'h1, borrow_out)
    run(0, 1, 1, 1, 4'h3, 8'h19);
    `CHK("m319", 8'h0c, mem[12'h319])
    `CHK("w", 8'h0d, working_register)
    `CHK("c", 1'h1, borrow_out)
    run(0, 0, 1, 0, 4'h3, 8'h19);
    `CHK("w", 8'hfe, working_register)
    `CHK("m319", 8'h0c, mem[12'h319])
    `CHK("c", 1'h0, borrow_out)
    run(1, 1, 0, 0, 4'h5, 8'hab);
    `CHK("m0ab", 8'h0d, mem[12'h0ab])
    `CHK("c", 1'h0, borrow_out)
    summarize();
  end
endmodule
